// file: src/htc_pkg.sv
package htc_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned IRQ_W  = 3;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_PRESCALE  = 8'h04;
   localparam logic [7:0] OFS_TOP       = 8'h08;
   localparam logic [7:0] OFS_COMPARE   = 8'h0C;
   localparam logic [7:0] OFS_COUNT     = 8'h10;
   localparam logic [7:0] OFS_CAPTURE   = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;
   localparam logic [7:0] OFS_IRQ_FORCE = 8'h20;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_MODE_LSB   = 0;
   localparam int unsigned CTRL_MODE_W     = 2;
   localparam int unsigned CTRL_ENABLE_BIT = 2;
   localparam int unsigned CTRL_DOWN_BIT   = 3;
   localparam int unsigned CTRL_CLKSEL_BIT = 4;
   localparam int unsigned CTRL_RSTEN_BIT  = 5;
   localparam int unsigned CTRL_CAPEN_BIT  = 6;
   localparam int unsigned CTRL_INVERT_BIT = 7;
   localparam int unsigned CTRL_WAKEEN_BIT = 8;
   localparam int unsigned CTRL_W          = 9;

   // ----------------------------------------------------------------
   // Interrupt bits
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_OVF_BIT = 0;
   localparam int unsigned IRQ_CMP_BIT = 1;
   localparam int unsigned IRQ_CAP_BIT = 2;

   // ----------------------------------------------------------------
   // Reset and preload values
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] RST_CTRL     = 9'h020;
   localparam logic [CNT_W-1:0]  RST_PRESCALE = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_TOP      = 16'hFFFF;
   localparam logic [CNT_W-1:0]  RST_COMPARE  = 16'h8000;
   localparam logic [IRQ_W-1:0]  RST_IRQ_MASK = 3'h0;
   localparam logic [CNT_W-1:0]  CNT_MAX      = 16'hFFFF;

   // ----------------------------------------------------------------
   // Operating modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      HTC_MODE_WDT,
      HTC_MODE_CTC,
      HTC_MODE_FPWM,
      HTC_MODE_PFC
   } htc_mode_t;

endpackage

// file: src/htc_timer.sv
`timescale 1ns/1ps
// What this block does
// - Sixteen-bit up/down counter with compare and PWM
// - Watchdog, clear-on-match, fast PWM, phase-correct PWM
// - Overflow, compare, capture interrupts each enabled
// - Synchronised capture edge stamps count, non-PWM and non-standalone only
// - Standalone irq is overflow flag, else masked
// - External active-low reset always honoured
// - Selectable count clock through programmable prescaler
// - PWM period and duty updated glitch-free
// - Separate wake-up interrupt to standby control
// - Standalone runs from the settings held on entry (preloads after reset), bus writes refused, reads allowed
// - Host reads and writes registers over bus
module htc_timer
#(
   parameter int unsigned             PRESC_W       = 16,
   parameter logic [8:0]              PRELOAD_CTRL  = htc_pkg::RST_CTRL,
   parameter logic [15:0]             PRELOAD_PRESC = htc_pkg::RST_PRESCALE,
   parameter logic [15:0]             PRELOAD_TOP   = htc_pkg::RST_TOP,
   parameter logic [15:0]             PRELOAD_CMP   = htc_pkg::RST_COMPARE,
   parameter logic [2:0]              PRELOAD_MASK  = htc_pkg::RST_IRQ_MASK
)
(
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [htc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [htc_pkg::DATA_W-1:0]   pwdata,
   output logic      [htc_pkg::DATA_W-1:0]   prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         standalone_mode,
   input  wire logic                         counter_clock_in,
   input  wire logic                         counter_reset_low,
   input  wire logic                         capture_trigger_in,
   output logic                              compare_wave_out,
   output logic                              counter_irq_out,
   output logic                              wake_irq_out,
   output logic      [htc_pkg::CNT_W-1:0]    current_count
);
   import htc_pkg::*;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (PRESC_W < 1 || PRESC_W > CNT_W)
   begin : g_bad_presc
      $error("PRESC_W must lie between 1 and 16");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [CTRL_W-1:0]  ctrl_ff;
   logic [PRESC_W-1:0] presc_ff;
   logic [CNT_W-1:0]   top_ff, cmp_ff;
   logic [CNT_W-1:0]   top_act_ff, cmp_act_ff;
   logic [CNT_W-1:0]   count_ff, nxt_count;
   logic               up_ff, nxt_up;
   logic [CNT_W-1:0]   capture_value_reg;
   logic [IRQ_W-1:0]   irq_stat_ff;
   logic [IRQ_W-1:0]   irq_mask_ff;
   logic [PRESC_W-1:0] presc_cnt_ff;
   logic               clk_prev_ff, cap_meta_ff, cap_sync_ff, cap_prev_ff, wave_ff;
   logic [DATA_W-1:0]  prdata_ff;
   htc_mode_t          mode;
   logic               enable, count_down, clk_sel, reset_input_enable, capture_en;
   logic               wave_invert, wake_en, is_pwm, ext_rst, src_tick, tick;
   logic               ovf_evt, cmp_evt, cap_evt, period_end;
   logic               bus_access, bus_wr, addr_hit;
   logic               wr_ctrl, wr_presc, wr_top, wr_cmp, wr_count, wr_stat, wr_mask, wr_force;
   logic [IRQ_W-1:0]   irq_set, irq_clr;
   logic [DATA_W-1:0]  rd_mux;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   assign mode               = htc_mode_t'(ctrl_ff[CTRL_MODE_LSB +: CTRL_MODE_W]);
   assign enable             = ctrl_ff[CTRL_ENABLE_BIT];
   assign count_down         = ctrl_ff[CTRL_DOWN_BIT];
   assign clk_sel            = ctrl_ff[CTRL_CLKSEL_BIT];
   assign reset_input_enable = ctrl_ff[CTRL_RSTEN_BIT];
   assign capture_en         = ctrl_ff[CTRL_CAPEN_BIT];
   assign wave_invert        = ctrl_ff[CTRL_INVERT_BIT];
   assign wake_en            = ctrl_ff[CTRL_WAKEEN_BIT];
   assign is_pwm             = (mode == HTC_MODE_FPWM) || (mode == HTC_MODE_PFC);
   assign ext_rst            = reset_input_enable && !counter_reset_low;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign bus_access = psel && penable;
   assign bus_wr     = bus_access && pwrite && !standalone_mode;
   assign addr_hit   = (paddr == OFS_CTRL) || (paddr == OFS_PRESCALE) ||
                       (paddr == OFS_TOP) || (paddr == OFS_COMPARE) ||
                       (paddr == OFS_COUNT) || (paddr == OFS_CAPTURE) ||
                       (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK) ||
                       (paddr == OFS_IRQ_FORCE);
   assign wr_ctrl    = bus_wr && (paddr == OFS_CTRL);
   assign wr_presc   = bus_wr && (paddr == OFS_PRESCALE);
   assign wr_top     = bus_wr && (paddr == OFS_TOP);
   assign wr_cmp     = bus_wr && (paddr == OFS_COMPARE);
   assign wr_count   = bus_wr && (paddr == OFS_COUNT);
   assign wr_stat    = bus_wr && (paddr == OFS_IRQ_STAT);
   assign wr_mask    = bus_wr && (paddr == OFS_IRQ_MASK);
   assign wr_force   = bus_wr && (paddr == OFS_IRQ_FORCE);
   assign pready     = 1'b1;
   assign pslverr    = bus_access && (!addr_hit || (pwrite && standalone_mode));
   assign prdata     = prdata_ff;

   always_comb
   begin
      rd_mux = '0;
      unique case (paddr)
         OFS_CTRL      : rd_mux[CTRL_W-1:0] = ctrl_ff;
         OFS_PRESCALE  : rd_mux[PRESC_W-1:0] = presc_ff;
         OFS_TOP       : rd_mux[CNT_W-1:0] = top_ff;
         OFS_COMPARE   : rd_mux[CNT_W-1:0] = cmp_ff;
         OFS_COUNT     : rd_mux[CNT_W-1:0] = count_ff;
         OFS_CAPTURE   : rd_mux[CNT_W-1:0] = capture_value_reg;
         OFS_IRQ_STAT  : rd_mux[IRQ_W-1:0] = irq_stat_ff;
         OFS_IRQ_MASK  : rd_mux[IRQ_W-1:0] = irq_mask_ff;
         default       : rd_mux = '0;
      endcase
   end

   // Read data latched in the setup cycle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         prdata_ff <= '0;
      else if (psel && !penable && !pwrite)
         prdata_ff <= rd_mux;
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_ff     <= PRELOAD_CTRL | CTRL_W'(1 << CTRL_RSTEN_BIT);
         presc_ff    <= PRELOAD_PRESC[PRESC_W-1:0];
         top_ff      <= PRELOAD_TOP;
         cmp_ff      <= PRELOAD_CMP;
         irq_mask_ff <= PRELOAD_MASK;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_ff                 <= pwdata[CTRL_W-1:0];
            ctrl_ff[CTRL_RSTEN_BIT] <= 1'b1;
         end
         if (wr_presc)
            presc_ff <= pwdata[PRESC_W-1:0];
         if (wr_top)
            top_ff <= pwdata[CNT_W-1:0];
         if (wr_cmp)
            cmp_ff <= pwdata[CNT_W-1:0];
         if (wr_mask)
            irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Clock source and prescaler
   // ----------------------------------------------------------------
   assign src_tick = clk_sel ? (counter_clock_in && !clk_prev_ff) : 1'b1;
   assign tick     = enable && !ext_rst && src_tick && (presc_cnt_ff >= presc_ff);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         clk_prev_ff <= 1'b0;
      else
         clk_prev_ff <= counter_clock_in;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || ext_rst || !enable)
         presc_cnt_ff <= '0;
      else if (src_tick)
         presc_cnt_ff <= (presc_cnt_ff >= presc_ff) ? '0 : presc_cnt_ff + PRESC_W'(1);
   end

   // ----------------------------------------------------------------
   // Counter next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_count  = count_ff;
      nxt_up     = up_ff;
      ovf_evt    = 1'b0;
      period_end = 1'b0;
      unique case (mode)
         HTC_MODE_WDT, HTC_MODE_CTC :
         begin
            if (count_down)
            begin
               if (count_ff == '0)
               begin
                  nxt_count = (mode == HTC_MODE_WDT) ? CNT_MAX : cmp_ff;
                  ovf_evt   = 1'b1;
               end
               else
                  nxt_count = count_ff - CNT_W'(1);
            end
            else if (count_ff >= ((mode == HTC_MODE_WDT) ? CNT_MAX : cmp_ff))
            begin
               nxt_count = '0;
               ovf_evt   = 1'b1;
            end
            else
               nxt_count = count_ff + CNT_W'(1);
         end
         HTC_MODE_FPWM :
         begin
            if (count_ff >= top_act_ff)
            begin
               nxt_count  = '0;
               ovf_evt    = 1'b1;
               period_end = 1'b1;
            end
            else
               nxt_count = count_ff + CNT_W'(1);
         end
         HTC_MODE_PFC :
         begin
            if (top_act_ff == '0)
            begin
               nxt_count  = '0;
               ovf_evt    = 1'b1;
               period_end = 1'b1;
            end
            else if (up_ff)
            begin
               if (count_ff >= top_act_ff)
               begin
                  nxt_count = count_ff - CNT_W'(1);
                  nxt_up    = 1'b0;
               end
               else
                  nxt_count = count_ff + CNT_W'(1);
            end
            else if (count_ff == '0)
            begin
               nxt_count  = CNT_W'(1);
               nxt_up     = 1'b1;
               ovf_evt    = 1'b1;
               period_end = 1'b1;
            end
            else
               nxt_count = count_ff - CNT_W'(1);
         end
      endcase
   end

   assign cmp_evt = tick && (count_ff == cmp_act_ff);

   // ----------------------------------------------------------------
   // Counter and shadow registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst || ext_rst)
      begin
         count_ff <= '0;
         up_ff    <= 1'b1;
      end
      else if (wr_count)
         count_ff <= pwdata[CNT_W-1:0];
      else if (tick)
      begin
         count_ff <= nxt_count;
         up_ff    <= nxt_up;
      end
   end

   // Period and duty take effect at a period boundary in enabled PWM modes, next cycle otherwise
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         top_act_ff <= PRELOAD_TOP;
         cmp_act_ff <= PRELOAD_CMP;
      end
      else if (!enable || !is_pwm || (tick && period_end))
      begin
         top_act_ff <= top_ff;
         cmp_act_ff <= cmp_ff;
      end
   end

   // ----------------------------------------------------------------
   // Waveform output
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst || ext_rst)
         wave_ff <= 1'b0;
      else if (is_pwm)
         wave_ff <= (count_ff < cmp_act_ff);
      else if (cmp_evt)
         wave_ff <= !wave_ff;
   end

   assign compare_wave_out = wave_ff ^ wave_invert;

   // ----------------------------------------------------------------
   // Input capture
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cap_meta_ff <= 1'b0;
         cap_sync_ff <= 1'b0;
         cap_prev_ff <= 1'b0;
      end
      else
      begin
         cap_meta_ff <= capture_trigger_in;
         cap_sync_ff <= cap_meta_ff;
         cap_prev_ff <= cap_sync_ff;
      end
   end

   assign cap_evt = capture_en && !is_pwm && !standalone_mode &&
                    cap_sync_ff && !cap_prev_ff;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         capture_value_reg <= '0;
      else if (cap_evt)
         capture_value_reg <= count_ff;
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_set = {cap_evt, cmp_evt, tick && ovf_evt} |
                    (wr_force ? pwdata[IRQ_W-1:0] : '0);
   assign irq_clr = wr_stat ? pwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq_stat_ff <= '0;
      else
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
   end

   assign counter_irq_out = standalone_mode ? irq_stat_ff[IRQ_OVF_BIT] :
                            |(irq_stat_ff & irq_mask_ff);
   assign wake_irq_out    = wake_en && counter_irq_out;
   assign current_count   = count_ff;

endmodule

// file: verification/htc_apb_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host bus master model
// ----------------------------------------------------------------
module htc_apb_host
(
   input  wire logic                       ref_clk,
   output logic                            psel,
   output logic                            penable,
   output logic                            pwrite,
   output logic      [htc_pkg::ADDR_W-1:0] paddr,
   output logic      [htc_pkg::DATA_W-1:0] pwdata,
   input  wire logic [htc_pkg::DATA_W-1:0] prdata,
   input  wire logic                       pready,
   input  wire logic                       pslverr
);
   import htc_pkg::*;
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end
   // One transfer, held until ready is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
   endtask
endmodule

// file: verification/htc_timer_chk.sv
`timescale 1ns/1ps
module htc_timer_chk
#(
   parameter logic [8:0] PRELOAD_CTRL = htc_pkg::RST_CTRL
)
(
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [htc_pkg::ADDR_W-1:0] paddr,
   input wire logic [htc_pkg::DATA_W-1:0] pwdata,
   input wire logic [htc_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       standalone_mode,
   input wire logic                       counter_clock_in,
   input wire logic                       counter_reset_low,
   input wire logic                       capture_trigger_in,
   input wire logic                       compare_wave_out,
   input wire logic                       counter_irq_out,
   input wire logic                       wake_irq_out,
   input wire logic [htc_pkg::CNT_W-1:0]  current_count
);
   import htc_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_ready_always: assert property (psel && penable |-> pready)
      else $error("ready low in access");
   a_unmapped_err: assert property (psel && penable && paddr > OFS_IRQ_FORCE
      |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
   a_mapped_ok: assert property (psel && penable && !pwrite && !standalone_mode
      && paddr <= OFS_IRQ_FORCE && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped read refused");
   a_standalone_wr: assert property (psel && penable && pwrite && standalone_mode
      |-> pslverr) else $error("standalone write accepted");
   a_err_phase: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
   a_rdata_hold: assert property (psel && penable && !pwrite |=> $stable(prdata))
      else $error("read data moved");
   a_wake_gated: assert property (wake_irq_out |-> counter_irq_out)
      else $error("wake without irq");
   a_reset_clear: assert property ($fell(rst) |-> current_count == 16'h0000
      && !counter_irq_out && compare_wave_out == PRELOAD_CTRL[CTRL_INVERT_BIT])
      else $error("reset state wrong");
   a_low_reset: assert property (!counter_reset_low ##1 !counter_reset_low
      |-> current_count == 16'h0000) else $error("count not held by reset pin");
   c_unmapped: cover property (psel && penable && pslverr && !pwrite);
   c_standalone: cover property (psel && penable && pwrite && standalone_mode);
   c_wake: cover property ($rose(wake_irq_out));
endmodule
bind htc_timer htc_timer_chk #(.PRELOAD_CTRL(PRELOAD_CTRL)) u_htc_timer_chk
   (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standalone_mode(standalone_mode),
    .counter_clock_in(counter_clock_in), .counter_reset_low(counter_reset_low),
    .capture_trigger_in(capture_trigger_in), .compare_wave_out(compare_wave_out),
    .counter_irq_out(counter_irq_out), .wake_irq_out(wake_irq_out),
    .current_count(current_count));

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import htc_pkg::*;
   logic        ref_clk = 0, rst = 1, standalone_mode = 0, counter_clock_in = 0;
   logic        counter_reset_low = 1, capture_trigger_in = 0;
   logic        psel, penable, pwrite, pready, pslverr, e;
   logic        compare_wave_out, counter_irq_out, wake_irq_out;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, seed = 32'h33bfe397;
   logic [15:0] current_count, v;
   int          errors = 0, total_checks = 0, cyc = 0, n, hi, tg, t, c, i;
   always #2.5 ref_clk = ~ref_clk;
   htc_timer u_htc_timer (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .standalone_mode(standalone_mode),
      .counter_clock_in(counter_clock_in), .counter_reset_low(counter_reset_low),
      .capture_trigger_in(capture_trigger_in), .compare_wave_out(compare_wave_out),
      .counter_irq_out(counter_irq_out), .wake_irq_out(wake_irq_out),
      .current_count(current_count));
   htc_apb_host u_htc_apb_host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [31:0] cw(input logic [1:0] m, input logic dn, cap, ck, wk);
      return {23'h0, wk, 1'b0, cap, 1'b1, ck, dn, 1'b1, m};
   endfunction
   function int period(input logic [1:0] m, input int top);
      return (m == 2'd3) ? 2 * top : top + 1;
   endfunction
   task chk(input logic [31:0] s, x, input string nm);
      total_checks++;
      if (s !== x)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      u_htc_apb_host.xfer(1'b1, a, d, q, e);
   endtask
   task rd(input logic [7:0] a);
      u_htc_apb_host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task tick();
      @(posedge ref_clk);
      #1;
   endtask
   task meas(input logic [15:0] val);
      logic w;
      #1;
      for (int k = 0; k < 400 && current_count !== val; k++) tick();
      n = 0; hi = 0; tg = 0;
      do
      begin
         w = compare_wave_out;
         tick();
         n++;
         hi += (compare_wave_out === 1'b1);
         tg += (compare_wave_out !== w);
      end
      while (current_count !== val && n < 400);
   endtask
   task done(input string s);
      $display("test %s ended, errors %0d", s, errors);
   endtask
   task end_of_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rd(OFS_CTRL);     chk(q, {23'h0, RST_CTRL}, "ctrl");
      rd(OFS_PRESCALE); chk(q, {16'h0, RST_PRESCALE}, "prescale");
      rd(OFS_TOP);      chk(q, {16'h0, RST_TOP}, "top");
      rd(OFS_COMPARE);  chk(q, {16'h0, RST_COMPARE}, "compare");
      rd(OFS_IRQ_MASK); chk(q, {29'h0, RST_IRQ_MASK}, "mask");
      rd(8'h24);        chk({31'h0, e}, 1, "unmapped");
      wr(OFS_CTRL, 0); rd(OFS_CTRL); chk(q, 32'h20, "rst enable");
      done("registers");
      t = rnd() % 4;
      wr(OFS_PRESCALE, t);
      wr(OFS_CTRL, cw(0, 0, 0, 0, 0));
      for (i = 0; i < 2; i++)
      begin
         v = current_count;
         n = 0;
         do begin tick(); n++; end while (current_count === v && n < 20);
      end
      chk(n, t + 1, "prescale period");
      chk(current_count, v + 16'h1, "step");
      wr(OFS_PRESCALE, 0); wr(OFS_IRQ_MASK, 1); wr(OFS_IRQ_STAT, 7);
      wr(OFS_CTRL, cw(0, 1, 0, 0, 0)); wr(OFS_COUNT, 3);
      for (i = 0; i < 20 && current_count !== 16'hFFFF; i++) tick();
      chk(current_count, 16'hFFFF, "down wrap");
      repeat (2) tick();
      chk(counter_irq_out, 1, "overflow irq");
      wr(OFS_IRQ_STAT, 1); #1; chk(counter_irq_out, 0, "clear");
      wr(OFS_IRQ_FORCE, 6); #1; chk(counter_irq_out, 0, "masked");
      rd(OFS_IRQ_STAT); chk(q, 6, "status");
      wr(OFS_IRQ_MASK, 7); wr(OFS_CTRL, cw(0, 1, 0, 0, 1)); #1;
      chk(wake_irq_out, 1, "wake");
      done("interrupts");
      c = 3 + rnd() % 8;
      wr(OFS_COMPARE, c); wr(OFS_CTRL, cw(1, 0, 0, 0, 0)); wr(OFS_COUNT, 0);
      meas(0); meas(0);
      chk(n, period(1, c), "ctc period");
      chk(tg, 1, "ctc toggle");
      rd(OFS_IRQ_STAT); chk({31'h0, q[1]}, 1, "match flag");
      t = 6 + rnd() % 8;
      c = 1 + rnd() % (t - 1);
      wr(OFS_TOP, t); wr(OFS_COMPARE, c); wr(OFS_CTRL, cw(2, 0, 0, 0, 0)); wr(OFS_COUNT, 0);
      meas(0); meas(0);
      chk(n, period(2, t), "pwm period");
      chk(hi, c, "pwm duty");
      wr(OFS_TOP, t + 5);
      meas(0); chk(tg, 2, "pwm change");
      meas(0); chk(n, period(2, t + 5), "new period");
      chk(hi, c, "new duty");
      wr(OFS_CTRL, cw(3, 0, 0, 0, 0)); wr(OFS_COUNT, 0);
      meas(0); meas(0);
      chk(n, period(3, t + 5), "pfc period");
      done("modes");
      for (i = 0; i < 2; i++)
      begin
         wr(OFS_CTRL, cw(i ? 2'd2 : 2'd0, 0, 1, 0, 0)); wr(OFS_IRQ_STAT, 7);
         @(posedge ref_clk);
         capture_trigger_in <= 1'b1;
         #1 v = current_count;
         repeat (6) @(posedge ref_clk);
         capture_trigger_in <= 1'b0;
         rd(OFS_IRQ_STAT); chk({31'h0, q[2]}, i ? 0 : 1, "capture flag");
      end
      wr(OFS_CTRL, cw(0, 0, 1, 0, 0)); wr(OFS_IRQ_STAT, 7);
      @(posedge ref_clk);
      capture_trigger_in <= 1'b1;
      #1 v = current_count;
      repeat (6) @(posedge ref_clk);
      capture_trigger_in <= 1'b0;
      rd(OFS_CAPTURE); chk({31'h0, (q[15:0] - v) <= 16'h4}, 1, "stamp");
      wr(OFS_CTRL, cw(0, 0, 0, 1, 0)); #1;
      v = current_count;
      for (i = 0; i < 8; i++)
      begin
         repeat (2 + rnd() % 3) @(posedge ref_clk);
         counter_clock_in <= ~counter_clock_in;
      end
      repeat (4) tick();
      chk(current_count - v, 4, "ext clock");
      wr(OFS_CTRL, cw(0, 0, 0, 0, 0) | (1 << CTRL_INVERT_BIT));
      @(posedge ref_clk);
      counter_reset_low <= 1'b0;
      repeat (3) tick();
      chk(current_count, 0, "reset pin");
      chk(compare_wave_out, 1, "inverted wave");
      @(posedge ref_clk);
      counter_reset_low <= 1'b1;
      done("capture and clocks");
      wr(OFS_IRQ_STAT, 7); wr(OFS_COUNT, 16'hFFF0);
      @(posedge ref_clk);
      standalone_mode <= 1'b1;
      tick();
      chk(counter_irq_out, 0, "flag idle");
      for (i = 0; i < 40 && counter_irq_out !== 1'b1; i++) tick();
      chk(counter_irq_out, 1, "overflow flag");
      wr(OFS_CTRL, 0); chk({31'h0, e}, 1, "standalone write");
      done("standalone");
      end_of_test();
   end
endmodule
